//--- i2c_expander_pkg.sv
/*
 * Shared constants and types for the expander's bus target logic.
 * Assumes a single system clock; bus lines arrive asynchronously.
 */
`default_nettype none
package i2c_expander_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_SRC_PORT0 = 8'h4c;
    localparam logic [7:0] OFS_IRQ_SRC_PORT1 = 8'h4d;
    localparam logic [7:0] OFS_OUTPUT_STAGE = 8'h4f;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int PORT0_STAGE_BIT = 0;
    localparam int PORT1_STAGE_BIT = 1;
    localparam logic [7:0] OUTPUT_STAGE_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [1:0] LOWER_ON_RESET = 2'h3;
    // ------------------------------------------------------------
    // Bus framing counts
    // ------------------------------------------------------------
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    // Both bus lines sampled together
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ} target_state_t;
endpackage : i2c_expander_pkg
`default_nettype wire

//--- i2c_expander_register_access.sv
/*
 * Bus target of a 16-bit I/O expander: address match, command pointer with
 * pair toggling, output-stage configuration and interrupt-status readback.
 * Assumes external pull-ups on SCL/SDA and that the caller resolves SDA from
 * o_sda_oe_n; source and mask vectors come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
// Contract
// (R1) Stage bit 0 gives push-pull, 1 gives open-drain with upper transistor off.
// (R2) Stage register bit 0 is port 0, bit 1 port 1; others reserved, reset 0.
// (R3) Controller should program stage register before setting pins as outputs.
// (R4) Controller writes: address with write bit 0, then a command byte.
// (R5) Data byte after the command byte is stored in the selected register.
// (R6) Any number of data bytes is accepted in one write.
// (R7) Twenty-two registers form eleven pairs, the unit of pointer toggling.
// (R8) Each following written byte goes to the other register of the pair.
// (R9) Controller reads: write address plus command, repeated start, read address.
// (R10) Read returns the register chosen by the most recent command byte.
// (R11) Each further read byte alternates to the pair partner.
// (R12) Controller may read any count but must not acknowledge the last byte.
// (R13) After a repeated start without command, pointer is the last read's partner.
// (R14) Read data is captured at the rising edge of the acknowledge clock.
// (R15) A stop may end a transfer anytime; latest acknowledged data stays valid.
// (R16) A read without a command byte uses the held pointer, reset value 00.
// (R17) Status bits are read-only: 1 for interrupt source, 0 otherwise or masked.
// (R18) Pair toggling inverts the pointer's least significant bit per data byte.
module i2c_expander_register_access
    import i2c_expander_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = 7'h20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [15:0] i_irq_source,
    input wire logic [15:0] i_irq_mask,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    output logic o_port0_opendrain_sel,
    output logic o_port1_opendrain_sel,
    output logic [1:0] o_upper_output_transistor,
    output logic [1:0] o_lower_output_transistor
);
    // ------------------------------------------------------------
    // Line synchronisers and filtering
    // ------------------------------------------------------------
    bus_lines_t sync1_reg;
    bus_lines_t sync2_reg;
    bus_lines_t sync3_reg;
    bus_lines_t line_reg;
    bus_lines_t prev_reg;
    target_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] ptr_reg;
    logic [7:0] stage_reg;
    logic ack_pend_reg;
    logic rw_reg;
    logic first_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [3:0] cnt_after_fall;
    logic [7:0] rd_value;
    logic [7:0] rd_partner;
    logic data_write;

    // Three stages; a level only counts once stages two and three agree
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_reg <= '{scl: 1'b1, sda: 1'b1};
            sync2_reg <= '{scl: 1'b1, sda: 1'b1};
            sync3_reg <= '{scl: 1'b1, sda: 1'b1};
            line_reg <= '{scl: 1'b1, sda: 1'b1};
            prev_reg <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            sync1_reg <= '{scl: i_scl, sda: i_sda};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg.scl == sync3_reg.scl)
                line_reg.scl <= sync3_reg.scl;
            if (sync2_reg.sda == sync3_reg.sda)
                line_reg.sda <= sync3_reg.sda;
            prev_reg <= line_reg;
        end
    end

    // Edge and condition detection on the filtered lines
    assign scl_rise = line_reg.scl & ~prev_reg.scl;
    assign scl_fall = ~line_reg.scl & prev_reg.scl;
    assign start_cond = line_reg.scl & prev_reg.scl & prev_reg.sda & ~line_reg.sda;
    assign stop_cond = line_reg.scl & prev_reg.scl & ~prev_reg.sda & line_reg.sda;
    assign rx_byte = {rx_sh_reg[6:0], line_reg.sda};
    assign byte_done = scl_rise && (bit_cnt_reg == LAST_DATA_BIT);
    assign cnt_after_fall = (bit_cnt_reg == ACK_SLOT) ? 4'h0 : bit_cnt_reg + 4'h1;
    assign data_write = byte_done && (state_reg == ST_WRITE) && !first_reg;

    // ------------------------------------------------------------
    // Register read multiplexer
    // ------------------------------------------------------------
    // Status is sampled when the byte is loaded, so a change mid-byte
    // cannot tear the value the controller sees.
    function automatic logic [7:0] read_mux(input logic [7:0] sel);
        logic [7:0] val;
        val = 8'h00;
        unique case (sel)
            // (R17) masked sources read zero
            OFS_IRQ_SRC_PORT0: val = i_irq_source[7:0] & ~i_irq_mask[7:0];
            OFS_IRQ_SRC_PORT1: val = i_irq_source[15:8] & ~i_irq_mask[15:8];
            OFS_OUTPUT_STAGE: val = stage_reg;
            default: val = 8'h00;
        endcase
        return val;
    endfunction : read_mux

    // (R7) pairs differ only in pointer bit 0
    assign rd_value = read_mux(ptr_reg);
    assign rd_partner = read_mux({ptr_reg[7:1], ~ptr_reg[0]});

    // ------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------
    // Start always wins, so a repeated start re-enters address phase
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            rx_sh_reg <= 8'h00;
            ack_pend_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            // The SCL fall that closes a start wraps the count to bit 0,
            // so that fall is not counted as the end of a data bit.
            state_reg <= ST_ADDR;
            bit_cnt_reg <= ACK_SLOT;
            ack_pend_reg <= 1'b0;
        end
        else if (stop_cond)
        begin
            // (R15) stop ends the transfer, stored data kept
            state_reg <= ST_IDLE;
            ack_pend_reg <= 1'b0;
        end
        else if (state_reg != ST_IDLE)
        begin
            if (scl_rise && bit_cnt_reg < ACK_SLOT)
                rx_sh_reg <= rx_byte;
            if (byte_done && state_reg == ST_ADDR)
            begin
                ack_pend_reg <= (rx_byte[7:1] == TARGET_ADDR);
                rw_reg <= rx_byte[0];
                if (rx_byte[7:1] != TARGET_ADDR)
                    state_reg <= ST_IDLE;
            end
            // (R6) every written byte is acknowledged, no count limit
            if (byte_done && state_reg == ST_WRITE)
                ack_pend_reg <= 1'b1;
            if (scl_rise && bit_cnt_reg == ACK_SLOT)
            begin
                if (state_reg == ST_ADDR)
                begin
                    state_reg <= rw_reg ? ST_READ : ST_WRITE;
                    first_reg <= !rw_reg;
                end
                else if (state_reg == ST_WRITE)
                    first_reg <= 1'b0;
                else if (line_reg.sda)
                    state_reg <= ST_IDLE;
            end
            if (scl_fall)
            begin
                bit_cnt_reg <= cnt_after_fall;
                if (bit_cnt_reg == ACK_SLOT)
                    ack_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Pointer, read data capture
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        // (R16) held pointer, reset 00
        if (i_rst)
        begin
            ptr_reg <= POINTER_RESET;
            tx_sh_reg <= 8'h00;
        end
        else if (!start_cond && !stop_cond)
        begin
            if (byte_done && state_reg == ST_WRITE && first_reg)
                ptr_reg <= rx_byte;
            // (R18) invert pointer LSB after each written data byte, not the command byte
            if (data_write)
                ptr_reg[0] <= ~ptr_reg[0];
            // (R14) capture at rising edge of address acknowledge
            if (scl_rise && bit_cnt_reg == ACK_SLOT && state_reg == ST_ADDR && rw_reg)
                tx_sh_reg <= rd_value;
            // (R11) toggle and load the partner on every read acknowledge
            // (R13) NACKed byte toggles too, so a restart reads the partner
            if (scl_rise && bit_cnt_reg == ACK_SLOT && state_reg == ST_READ)
            begin
                ptr_reg[0] <= ~ptr_reg[0];
                if (!line_reg.sda)
                    tx_sh_reg <= rd_partner;
            end
        end
    end

    // ------------------------------------------------------------
    // Output-stage configuration register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            stage_reg <= OUTPUT_STAGE_RESET;
            o_upper_output_transistor <= ~OUTPUT_STAGE_RESET[1:0];
            o_lower_output_transistor <= LOWER_ON_RESET;
            o_port0_opendrain_sel <= OUTPUT_STAGE_RESET[PORT0_STAGE_BIT];
            o_port1_opendrain_sel <= OUTPUT_STAGE_RESET[PORT1_STAGE_BIT];
        end
        // (R5) store byte in selected register; reserved bits stay zero
        // (R2) only bits 1:0 are kept
        else if (data_write && ptr_reg == OFS_OUTPUT_STAGE && !start_cond && !stop_cond)
        begin
            stage_reg <= {6'h00, rx_byte[1:0]};
            // (R1) open-drain disables the upper transistor
            o_upper_output_transistor <= ~rx_byte[1:0];
            o_lower_output_transistor <= LOWER_ON_RESET;
            o_port0_opendrain_sel <= rx_byte[PORT0_STAGE_BIT];
            o_port1_opendrain_sel <= rx_byte[PORT1_STAGE_BIT];
        end
    end

    // ------------------------------------------------------------
    // SDA drive, changed on SCL falls; a start or stop releases it while SCL is high
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_sda_oe_n <= 1'b1;
            o_sda_out <= 1'b0;
        end
        else if (start_cond || stop_cond)
            o_sda_oe_n <= 1'b1;
        else if (scl_fall)
        begin
            if (cnt_after_fall == ACK_SLOT)
                o_sda_oe_n <= !ack_pend_reg;
            else if (state_reg == ST_READ)
                // (R10) shift out the captured register, MSB first
                o_sda_oe_n <= tx_sh_reg[~cnt_after_fall[2:0]];
            else
                o_sda_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_upper_follows_stage: assert property (o_upper_output_transistor == ~stage_reg[1:0]) // (R1)
        else $error("upper transistor enable disagrees with stage bits");
    a_lower_always_on: assert property (o_lower_output_transistor == 2'h3) // (R1)
        else $error("lower transistor not active");
    a_reserved_zero: assert property (stage_reg[7:2] == 6'h00 && o_port1_opendrain_sel == stage_reg[1]) // (R2)
        else $error("stage reserved bits set or port select mismatch");
    a_write_stores: assert property (data_write && ptr_reg == OFS_OUTPUT_STAGE && !start_cond && !stop_cond |=> stage_reg[1:0] == $past(rx_byte[1:0])) // (R5)
        else $error("write to stage register not stored");
    a_write_unlimited: assert property (state_reg == ST_WRITE && byte_done && !start_cond && !stop_cond |=> ack_pend_reg ##1 (state_reg == ST_WRITE || $past(start_cond) || $past(stop_cond))) // (R6)
        else $error("write byte not acknowledged");
    a_write_pair_toggle: assert property (data_write && !start_cond && !stop_cond |=> ptr_reg == {$past(ptr_reg[7:1]), ~$past(ptr_reg[0])}) // (R8)
        else $error("write pointer did not move to pair partner");
    a_read_pair_toggle: assert property (scl_rise && bit_cnt_reg == ACK_SLOT && state_reg == ST_READ && !start_cond && !stop_cond |=> ptr_reg[0] != $past(ptr_reg[0]) && ptr_reg[7:1] == $past(ptr_reg[7:1])) // (R13)
        else $error("read pointer did not toggle within pair");
    a_read_capture: assert property (scl_rise && bit_cnt_reg == ACK_SLOT && state_reg == ST_ADDR && rw_reg && !start_cond && !stop_cond |=> tx_sh_reg == $past(rd_value) && state_reg == ST_READ) // (R14)
        else $error("read data not captured at acknowledge edge");
    a_status_masked: assert property (scl_rise && bit_cnt_reg == ACK_SLOT && state_reg == ST_ADDR && rw_reg && ptr_reg == OFS_IRQ_SRC_PORT0 && !start_cond && !stop_cond |=> tx_sh_reg == $past(i_irq_source[7:0] & ~i_irq_mask[7:0])) // (R17)
        else $error("status readback ignores mask");
    a_stop_release: assert property (stop_cond |=> state_reg == ST_IDLE && o_sda_oe_n) // (R15)
        else $error("stop did not release bus");
endmodule : i2c_expander_register_access
`default_nettype wire

//--- i2c_ctrl_model.sv
/*
 * Bus controller model that drives SCL and the controller side of SDA.
 * Assumes the bench resolves the wired-AND data line and feeds it back.
 */
`timescale 1ns/1ns
`default_nettype none
module i2c_ctrl_model (
    input wire logic i_clk_sys,
    input wire logic i_sda_wire,
    output var logic o_scl,
    output var logic o_sda
);
    // ------------------------------------------------------------
    // Line primitives, one bus clock is 8 system clocks (160 ns)
    // ------------------------------------------------------------
    // Both lines idle released, the pull-ups hold them high
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : wait_clk
    // start also serves as repeated start
    task automatic start_cond();
        wait_clk(1);
        o_sda <= 1'b1;
        // Let the target release its acknowledge first, or the rising
        // SDA with SCL high would read as a stop
        wait_clk(7);
        o_scl <= 1'b1;
        wait_clk(4);
        o_sda <= 1'b0;
        wait_clk(4);
        o_scl <= 1'b0;
    endtask : start_cond
    // stop may end a transfer at any byte boundary
    task automatic stop_cond();
        wait_clk(1);
        o_sda <= 1'b0;
        wait_clk(4);
        o_scl <= 1'b1;
        wait_clk(4);
        o_sda <= 1'b1;
        wait_clk(4);
    endtask : stop_cond
    // Data set during low phase; line read mid-high so target updates have landed
    task automatic bit_xfer(input logic b, output logic r);
        wait_clk(1);
        o_sda <= b;
        wait_clk(4);
        o_scl <= 1'b1;
        wait_clk(2);
        r = i_sda_wire;
        wait_clk(1);
        o_scl <= 1'b0;
    endtask : bit_xfer
    // MSB first, then the acknowledge slot; ack_in 1 releases it
    task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], q[i]);
        bit_xfer(ack_in, ack);
    endtask : byte_xfer
endmodule : i2c_ctrl_model
`default_nettype wire

//--- i2c_expander_register_access_bench.sv
/*
 * Self-checking bench for the expander bus target, with a controller model.
 * Assumes the design package is compiled first; SDA has a pull-up here.
 */
`timescale 1ns/1ns
`default_nettype none
module i2c_expander_register_access_bench;
    import i2c_expander_pkg::*;
    localparam logic [6:0] TADDR = 7'h20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] irq_source = 16'ha5c3;
    logic [15:0] irq_mask = 16'h00f0;
    logic scl, sda_ctrl, sda_out, sda_oe_n, sel0, sel1;
    logic [1:0] upper, lower;
    wire logic sda_wire;
    int err_count = 0;
    int n_tests = 0;
    // ------------------------------------------------------------
    // Clock, wire resolution and instances
    // ------------------------------------------------------------
    always #10 clk_sys = ~clk_sys;
    // Wired-AND with pull-up: either party may pull low
    assign sda_wire = sda_ctrl & (sda_oe_n | sda_out);
    i2c_expander_register_access #(.TARGET_ADDR(TADDR)) i_dut (.i_clk_sys(clk_sys),
        .i_rst(rst), .i_scl(scl), .i_sda(sda_wire), .i_irq_source(irq_source),
        .i_irq_mask(irq_mask), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .o_port0_opendrain_sel(sel0), .o_port1_opendrain_sel(sel1),
        .o_upper_output_transistor(upper), .o_lower_output_transistor(lower));
    i2c_ctrl_model i_ctrl (.i_clk_sys(clk_sys), .i_sda_wire(sda_wire), .o_scl(scl),
        .o_sda(sda_ctrl));
    // ------------------------------------------------------------
    // Compare and report tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
            err_count++;
        end
    endtask : chk8
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
            err_count++;
        end
    endtask : chk_bit
    // Selects follow the stage bits, upper is their inverse, lower always on
    task automatic chk_stage(input logic [1:0] st);
        chk8({2'h0, sel1, sel0, upper, lower}, {2'h0, st, ~st, 2'h3}, "stage outputs");
    endtask : chk_stage
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // Bus access tasks
    // ------------------------------------------------------------
    task automatic send_addr(input logic rd);
        logic [7:0] q;
        logic ack;
        i_ctrl.start_cond();
        i_ctrl.byte_xfer({TADDR, rd}, 1'b1, q, ack);
        chk_bit(ack, 1'b0, "address ack");
    endtask : send_addr
    task automatic reg_write(input logic [7:0] cmd, input logic [7:0] d[$]);
        logic [7:0] q;
        logic ack;
        send_addr(1'b0);
        i_ctrl.byte_xfer(cmd, 1'b1, q, ack);
        chk_bit(ack, 1'b0, "command ack");
        foreach (d[i])
        begin
            i_ctrl.byte_xfer(d[i], 1'b1, q, ack);
            chk_bit(ack, 1'b0, "data ack");
        end
        i_ctrl.stop_cond();
    endtask : reg_write
    // Optional command phase, then repeated start and a read; last byte NACKed
    task automatic reg_read(input logic use_cmd, input logic [7:0] cmd,
        input logic [7:0] exp[$], input logic do_stop);
        logic [7:0] q;
        logic ack;
        if (use_cmd)
        begin
            send_addr(1'b0);
            i_ctrl.byte_xfer(cmd, 1'b1, q, ack);
        end
        send_addr(1'b1);
        foreach (exp[i])
        begin
            i_ctrl.byte_xfer(8'hff, (i == exp.size() - 1), q, ack);
            chk8(q, exp[i], "read byte");
        end
        if (do_stop)
            i_ctrl.stop_cond();
    endtask : reg_read
    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        $display("CHECK FAILED at %0t: run did not finish", $time);
        err_count++;
        results();
    end
    initial
    begin
        logic [7:0] q;
        logic ack;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        i_ctrl.wait_clk(8);
        chk_stage(2'h0);
        reg_read(1'b0, 8'h00, '{8'h00}, 1'b1);
        $display("test reset and held pointer done");
        // stage configured before any port becomes an output
        reg_write(OFS_OUTPUT_STAGE, '{8'h03, 8'haa, 8'hfe});
        chk_stage(2'h2);
        reg_read(1'b1, OFS_OUTPUT_STAGE, '{8'h02, 8'h00, 8'h02}, 1'b0);
        reg_read(1'b0, 8'h00, '{8'h00, 8'h02}, 1'b1);
        $display("test pair toggling done");
        reg_write(OFS_IRQ_SRC_PORT1, '{8'hff, 8'hff});
        reg_read(1'b1, OFS_IRQ_SRC_PORT1, '{8'ha5, 8'h03}, 1'b1);
        irq_mask <= 16'hffff;
        reg_read(1'b1, OFS_IRQ_SRC_PORT0, '{8'h00, 8'h00}, 1'b1);
        $display("test status readback done");
        // Foreign address: no ack, and the rest of the frame is ignored
        i_ctrl.start_cond();
        i_ctrl.byte_xfer({TADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
        chk_bit(ack, 1'b1, "foreign address");
        i_ctrl.byte_xfer(OFS_OUTPUT_STAGE, 1'b1, q, ack);
        i_ctrl.byte_xfer(8'h01, 1'b1, q, ack);
        chk_bit(ack, 1'b1, "foreign data");
        i_ctrl.stop_cond();
        chk_stage(2'h2);
        reg_write(OFS_OUTPUT_STAGE, '{8'h01});
        chk_stage(2'h1);
        $display("test address and stop done");
        results();
    end
endmodule : i2c_expander_register_access_bench
`default_nettype wire
